// ### hw/svm_supply_monitor.sv
// Supply monitor controller: clocking, detection sequencing, flag and reset issue
// How it works
// RULE1 - Software unlocks key, clears enable, relocks
// RULE2 - Result reads 1 below threshold, else 0
// RULE3 - Software waits enable response before reading result
// RULE4 - Software waits after threshold change while enabled
// RULE5 - Mode 0 detects continuously, updating result
// RULE6 - Continuous low: interrupt, or reset if key 0xa
// RULE7 - Interval modes power, detect once, power off
// RULE8 - Interval mode fires after successive lows reached
// RULE9 - Interrupt request only when flag and enable
// RULE10 - Flag sticky; cleared only by writing 1
// RULE11 - Interrupt function only when key not 0xa
// RULE12 - Reset issued when flag would be set
// RULE13 - After reset issue, run continuous mode
// RULE14 - External sense stays routed during monitor reset
// RULE15 - Hold reset until result returns to 0
// RULE16 - Reset state restores clock control defaults
// RULE17 - Reset state clears count and mode fields
// RULE18 - Reset state keeps flag, clears interrupt enable
// RULE19 - Debug run gates detector clock in debug
// RULE20 - Clock source and divider code selection
// RULE21 - Count write effective only in interval mode
// RULE22 - Software aims detector clock near 32 kHz
// RULE23 - Interval periods 128, 256, 512 ticks
// RULE24 - Count codes need 1, 2, 4, 8 lows
// RULE25 - Disable resets detector; bit reads 0 afterwards
// RULE26 - Field change or flag clear restarts sequencing
// RULE27 - Comparator input sampled, latched at detection
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps
module svm_supply_monitor
    import svm_pkg::*;
#(
    parameter int SETTLE = SETTLE_TICKS
) (
    // Clock, reset, clock enable
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rd_data,
    // Detector clock sources, debug state
    input  wire logic              internal_oscillator,
    input  wire logic              low_speed_oscillator,
    input  wire logic              high_speed_oscillator,
    input  wire logic              external_clock_input,
    input  wire logic              debug_mode,
    // Analog comparator
    input  wire logic              comparator_low,
    output logic                   comparator_power,
    output logic      [4:0]        threshold_select,
    output logic                   supply_source_select,
    output logic                   external_sense_route,
    // System outputs
    output logic                   irq,
    output logic                   monitor_reset
);

    logic              rst_meta;
    logic              rst_n;
    logic [3:0]        src_meta;
    logic [3:0]        src_sync;
    logic [3:0]        src_prev;
    logic [3:0]        src_edge;
    logic              cmp_meta;
    logic              cmp_low;

    logic              debug_run;
    logic [2:0]        clock_divider;
    logic [1:0]        clock_source;
    logic [1:0]        successive_count;
    logic [3:0]        reset_issue_key;
    logic [1:0]        interval_mode;
    logic              detector_enable;
    logic              stopping;
    logic              low_voltage_flag;
    logic              low_voltage_irq_enable;
    logic              detection_result;
    logic [15:0]       protection_key;
    logic              reset_state;

    logic [6:0]        div_cnt;
    logic              tick;
    svm_state_type     state;
    logic [8:0]        period_cnt;
    logic [7:0]        settle_cnt;
    logic [3:0]        low_cnt;

    logic              unlocked;
    logic              wr_clk_ctl;
    logic              wr_ctl;
    logic              flag_clear;
    logic              restart;
    logic              sample;
    logic              trigger;
    logic              key_is_reset;
    logic [1:0]        next_succ;
    logic [6:0]        div_last;
    logic [8:0]        period_last;
    logic [3:0]        need;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Pin synchronisers: sources and comparator
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_src
            logic src_pin;
            assign src_pin = (g == 0) ? internal_oscillator :
                             (g == 1) ? low_speed_oscillator :
                             (g == 2) ? high_speed_oscillator : external_clock_input;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    src_meta[g] <= 1'b0;
                    src_sync[g] <= 1'b0;
                    src_prev[g] <= 1'b0;
                end else if (ce) begin
                    src_meta[g] <= src_pin;
                    src_sync[g] <= src_meta[g];
                    src_prev[g] <= src_sync[g];
                end
            end
            assign src_edge[g] = src_sync[g] & ~src_prev[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta <= 1'b0;
            cmp_low  <= 1'b0;
        end else if (ce) begin
            cmp_meta <= comparator_low;
            cmp_low  <= cmp_meta;
        end
    end

    // Decode
    assign unlocked     = (protection_key == PROT_UNLOCK);
    assign wr_clk_ctl   = wr_en && addr == OFS_CLOCK_CONTROL && unlocked;
    assign wr_ctl       = wr_en && addr == OFS_CONTROL && unlocked;
    assign flag_clear   = wr_en && addr == OFS_FLAG && wr_data[POS_FLAG];
    assign key_is_reset = (reset_issue_key == KEY_ISSUE_RST);
    assign next_succ    = (interval_mode != MODE_CONTINUOUS) ?
                          wr_data[POS_SUCC_COUNT +: 2] : successive_count; // RULE21

    // Sequencing restarts on count, reset key or mode change, or on clearing a set flag, while running
    assign restart = detector_enable && ((wr_ctl && (next_succ != successive_count ||
                     wr_data[POS_RESET_KEY +: 4] != reset_issue_key ||
                     wr_data[POS_MODE +: 2] != interval_mode)) ||
                     (flag_clear && low_voltage_flag)); // RULE26

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            protection_key <= RST_PROT_KEY;
        end else if (ce && wr_en && addr == OFS_PROTECTION_KEY) begin
            protection_key <= wr_data;
        end
    end

    // Clock control register; defaults forced while reset is issued
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_run     <= RST_DEBUG_RUN;
            clock_divider <= RST_CLOCK_DIV;
            clock_source  <= RST_CLOCK_SRC;
        end else if (ce) begin
            if (reset_state) begin
                debug_run     <= RST_DEBUG_RUN; // RULE16
                clock_divider <= RST_CLOCK_DIV;
                clock_source  <= RST_CLOCK_SRC;
            end else if (wr_clk_ctl) begin
                debug_run     <= wr_data[POS_DEBUG_RUN];
                clock_divider <= wr_data[POS_CLOCK_DIV +: 3];
                clock_source  <= wr_data[POS_CLOCK_SRC +: 2];
            end
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supply_source_select <= RST_SOURCE_SEL;
            successive_count     <= RST_SUCC_COUNT;
            threshold_select     <= RST_THRESHOLD;
            reset_issue_key      <= RST_RESET_KEY;
            interval_mode        <= RST_MODE;
        end else if (ce) begin
            if (reset_state || trigger && key_is_reset) begin
                successive_count <= RST_SUCC_COUNT; // RULE17
                interval_mode    <= MODE_CONTINUOUS; // RULE13
            end else if (wr_ctl) begin
                supply_source_select <= wr_data[POS_SOURCE_SEL];
                successive_count     <= next_succ;
                threshold_select     <= wr_data[POS_THRESHOLD +: 5];
                reset_issue_key      <= wr_data[POS_RESET_KEY +: 4];
                interval_mode        <= wr_data[POS_MODE +: 2];
            end
        end
    end

    // Enable bit drops only once the detector has been reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detector_enable <= 1'b0;
            stopping        <= 1'b0;
        end else if (ce) begin
            if (stopping) begin
                detector_enable <= 1'b0; // RULE25
                stopping        <= 1'b0;
            end else if (wr_ctl && !wr_data[POS_ENABLE] && detector_enable) begin
                stopping <= 1'b1; // RULE25
            end else if (wr_ctl && wr_data[POS_ENABLE]) begin
                detector_enable <= 1'b1;
            end
        end
    end

    // Detector clock: source select, divider, debug gating
    assign div_last = 7'((DIV_BASE << ((clock_divider > DIV_MAX) ? DIV_MAX : clock_divider)) - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 7'h00;
        end else if (ce && src_edge[clock_source]) begin
            div_cnt <= (div_cnt == div_last) ? 7'h00 : div_cnt + 7'h01;
        end
    end

    always_comb begin
        if (debug_mode && !debug_run) begin
            tick = 1'b0; // RULE19
        end else if (clock_source[0]) begin
            tick = src_edge[clock_source]; // RULE20
        end else begin
            tick = src_edge[clock_source] && div_cnt == div_last; // RULE20
        end
    end

    // Detection sequencer
    assign period_last = 9'((PERIOD_BASE << (interval_mode - 2'h1)) - 10'h001); // RULE23
    assign sample      = tick && state == SVM_SAMPLE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= SVM_IDLE;
            period_cnt <= 9'h000;
            settle_cnt <= 8'h00;
        end else if (ce) begin
            if (restart || stopping || !detector_enable) begin
                state      <= SVM_IDLE; // RULE25
                period_cnt <= 9'h000;
                settle_cnt <= 8'h00;
            end else if (tick) begin
                period_cnt <= period_cnt + 9'h001;
                case (state)
                    SVM_IDLE: begin
                        state      <= SVM_SETTLE;
                        period_cnt <= 9'h000;
                        settle_cnt <= 8'h00;
                    end
                    SVM_SETTLE: begin
                        settle_cnt <= settle_cnt + 8'h01;
                        if (settle_cnt >= 8'(SETTLE - 1)) begin
                            state <= SVM_SAMPLE;
                        end
                    end
                    SVM_SAMPLE: begin
                        if (interval_mode != MODE_CONTINUOUS) begin
                            state <= SVM_REST; // RULE7
                        end
                    end
                    SVM_REST: begin
                        if (interval_mode == MODE_CONTINUOUS || period_cnt >= period_last) begin
                            state      <= SVM_SETTLE; // RULE7
                            period_cnt <= 9'h000;
                            settle_cnt <= 8'h00;
                        end
                    end
                    default: begin
                        state <= SVM_IDLE;
                    end
                endcase
            end
        end
    end

    // Comparator powered only around a detection
    assign comparator_power = state == SVM_SETTLE || state == SVM_SAMPLE; // RULE7

    // Result latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detection_result <= 1'b0;
        end else if (ce && sample) begin
            detection_result <= cmp_low; // RULE27 RULE2 RULE5
        end
    end

    // Successive low counter
    assign need = 4'(4'h1 << successive_count); // RULE24

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 4'h0;
        end else if (ce) begin
            if (restart || stopping || !detector_enable) begin
                low_cnt <= 4'h0;
            end else if (sample) begin
                low_cnt <= (cmp_low && low_cnt + 4'h1 < need) ? low_cnt + 4'h1 : 4'h0;
            end
        end
    end

    always_comb begin
        if (!sample || !cmp_low) begin
            trigger = 1'b0;
        end else if (interval_mode == MODE_CONTINUOUS) begin
            trigger = 1'b1; // RULE6
        end else begin
            trigger = low_cnt + 4'h1 >= need; // RULE8
        end
    end

    // Sticky flag; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_voltage_flag <= 1'b0;
        end else if (ce) begin
            if (trigger) begin
                low_voltage_flag <= 1'b1; // RULE10 RULE12 RULE18
            end else if (flag_clear) begin
                low_voltage_flag <= 1'b0; // RULE10
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_voltage_irq_enable <= 1'b0;
        end else if (ce) begin
            if (reset_state || trigger && key_is_reset) begin
                low_voltage_irq_enable <= 1'b0; // RULE18
            end else if (wr_en && addr == OFS_IRQ_ENABLE) begin
                low_voltage_irq_enable <= wr_data[POS_IRQ_ENABLE];
            end
        end
    end

    // Reset issue, held until the result reads high supply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_state <= 1'b0;
        end else if (ce) begin
            if (trigger && key_is_reset) begin
                reset_state <= 1'b1; // RULE12 RULE6
            end else if (stopping || sample && !cmp_low) begin
                reset_state <= 1'b0; // RULE15
            end
        end
    end

    assign monitor_reset        = reset_state;
    assign irq                  = low_voltage_flag && low_voltage_irq_enable && !key_is_reset; // RULE9 RULE11
    assign external_sense_route = supply_source_select && detector_enable; // RULE14

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= '0;
            if (rd_en) begin
                case (addr)
                    OFS_CLOCK_CONTROL: begin
                        rd_data[POS_DEBUG_RUN]      <= debug_run;
                        rd_data[POS_CLOCK_DIV +: 3] <= clock_divider;
                        rd_data[POS_CLOCK_SRC +: 2] <= clock_source;
                    end
                    OFS_CONTROL: begin
                        rd_data[POS_SOURCE_SEL]      <= supply_source_select;
                        rd_data[POS_SUCC_COUNT +: 2] <= successive_count;
                        rd_data[POS_THRESHOLD +: 5]  <= threshold_select;
                        rd_data[POS_RESET_KEY +: 4]  <= reset_issue_key;
                        rd_data[POS_MODE +: 2]       <= interval_mode;
                        rd_data[POS_ENABLE]          <= detector_enable;
                    end
                    OFS_FLAG: begin
                        rd_data[POS_RESULT] <= detection_result;
                        rd_data[POS_FLAG]   <= low_voltage_flag;
                    end
                    OFS_IRQ_ENABLE: begin
                        rd_data[POS_IRQ_ENABLE] <= low_voltage_irq_enable;
                    end
                    OFS_PROTECTION_KEY: begin
                        rd_data <= protection_key;
                    end
                    default: begin
                        rd_data <= '0;
                    end
                endcase
            end
        end
    end

endmodule

// ### hw/svm_pkg.sv
// Constants and types of the supply monitor controller
package svm_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets (byte addresses of 16-bit registers)
    localparam logic [3:0] OFS_CLOCK_CONTROL  = 4'h0;
    localparam logic [3:0] OFS_CONTROL        = 4'h2;
    localparam logic [3:0] OFS_FLAG           = 4'h4;
    localparam logic [3:0] OFS_IRQ_ENABLE     = 4'h6;
    localparam logic [3:0] OFS_PROTECTION_KEY = 4'h8;

    // monitor_clock_control fields
    localparam int POS_DEBUG_RUN = 8;
    localparam int POS_CLOCK_DIV = 4;
    localparam int POS_CLOCK_SRC = 0;
    // monitor_control fields
    localparam int POS_SOURCE_SEL = 15;
    localparam int POS_SUCC_COUNT = 13;
    localparam int POS_THRESHOLD  = 8;
    localparam int POS_RESET_KEY  = 4;
    localparam int POS_MODE       = 1;
    localparam int POS_ENABLE     = 0;
    // monitor_flag_register fields
    localparam int POS_RESULT     = 8;
    localparam int POS_FLAG       = 0;
    // monitor_irq_enable_register fields
    localparam int POS_IRQ_ENABLE = 0;

    // Reset values
    localparam logic       RST_DEBUG_RUN  = 1'b1;
    localparam logic [2:0] RST_CLOCK_DIV  = 3'h0;
    localparam logic [1:0] RST_CLOCK_SRC  = 2'h0;
    localparam logic       RST_SOURCE_SEL = 1'b0;
    localparam logic [1:0] RST_SUCC_COUNT = 2'h0;
    localparam logic [4:0] RST_THRESHOLD  = 5'h1e;
    localparam logic [3:0] RST_RESET_KEY  = 4'h0;
    localparam logic [1:0] RST_MODE       = 2'h0;
    localparam logic [15:0] RST_PROT_KEY  = 16'h0000;

    // Codes
    localparam logic [15:0] PROT_UNLOCK   = 16'h0096;
    localparam logic [3:0]  KEY_ISSUE_RST = 4'ha;
    localparam logic [1:0]  MODE_CONTINUOUS = 2'h0;
    localparam logic [2:0]  DIV_MAX       = 3'h5;
    localparam logic [7:0]  DIV_BASE      = 8'h04;
    localparam logic [9:0]  PERIOD_BASE   = 10'h080;
    localparam int          SETTLE_TICKS  = 2;

    typedef enum logic [1:0] {
        SVM_IDLE   = 2'b00,
        SVM_SETTLE = 2'b01,
        SVM_SAMPLE = 2'b11,
        SVM_REST   = 2'b10
    } svm_state_type;
endpackage

// ### tb/svm_supply_monitor_chk.sv
// Port checks for the supply monitor controller
`timescale 1ns/10ps
module svm_chk
    import svm_pkg::*;
(
    // Clock, reset, enable
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              ce,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    // Analog side and outputs
    input wire logic              comparator_low,
    input wire logic [4:0]        threshold_select,
    input wire logic              supply_source_select,
    input wire logic              external_sense_route,
    input wire logic              irq,
    input wire logic              monitor_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic ctl_wr_q;
    // Control write seen one edge ago
    always_ff @(posedge clk) begin
        ctl_wr_q <= wr_en && addr == OFS_CONTROL;
    end
    property p_rd_idle;
        ce && !$past(rd_en) |-> rd_data == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_irq_off;
        ce && wr_en && addr == OFS_IRQ_ENABLE && !wr_data[POS_IRQ_ENABLE] |=> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq despite disable");
    property p_irq_key;
        monitor_reset |-> !irq;
    endproperty
    a_irq_key: assert property (p_irq_key) else $error("irq during reset issue");
    property p_route;
        external_sense_route |-> supply_source_select;
    endproperty
    a_route: assert property (p_route) else $error("sense routed unselected");
    property p_route_rst;
        monitor_reset && $past(monitor_reset) && supply_source_select |-> external_sense_route;
    endproperty
    a_route_rst: assert property (p_route_rst) else $error("sense dropped in reset");
    property p_thr;
        !$stable(threshold_select) |-> ctl_wr_q;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold changed alone");
    property p_src;
        !$stable(supply_source_select) |-> ctl_wr_q;
    endproperty
    a_src: assert property (p_src) else $error("source changed alone");
    property p_hold;
        comparator_low[*4] ##0 (monitor_reset && !ctl_wr_q && !(wr_en && addr == OFS_CONTROL)) |=> monitor_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("reset released while low");
    c_rst: cover property ($rose(monitor_reset));
    c_irq: cover property ($rose(irq));
    c_rd: cover property (rd_data != '0);
endmodule
bind svm_supply_monitor svm_chk u_svm_chk (
    .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .comparator_low(comparator_low),
    .threshold_select(threshold_select), .supply_source_select(supply_source_select),
    .external_sense_route(external_sense_route), .irq(irq), .monitor_reset(monitor_reset));

// ### tb/tb_top.sv
// Self-checking bench for the supply monitor controller
`timescale 1ns/10ps
module tb_top;
    import svm_pkg::*;
    logic              clk;
    logic              rstn;
    logic              ce;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              osc;
    logic [1:0]        osc_cnt;
    logic              debug_mode;
    logic              comparator_low;
    logic              comparator_power;
    logic [4:0]        threshold_select;
    logic              external_sense_route;
    logic              irq;
    logic              monitor_reset;
    int                bad_count;
    int                samples_checked;

    svm_supply_monitor u_svm_supply_monitor (
        .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .internal_oscillator(osc), .low_speed_oscillator(osc),
        .high_speed_oscillator(osc), .external_clock_input(osc), .debug_mode(debug_mode),
        .comparator_low(comparator_low), .comparator_power(comparator_power),
        .threshold_select(threshold_select), .supply_source_select(),
        .external_sense_route(external_sense_route), .irq(irq), .monitor_reset(monitor_reset));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Source clock of six system cycles
    always @(posedge clk) begin
        osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
        if (osc_cnt == 2'h2) osc <= ~osc;
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // Bounded wait on irq or on the issued reset
    task automatic wait_for(input bit on_rst, input logic val, input int lim);
        int n;
        n = 0;
        while (((on_rst ? monitor_reset : irq) !== val) && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        if ((on_rst ? monitor_reset : irq) !== val) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, (on_rst ? monitor_reset : irq), val);
            stop_test();
        end
    endtask

    task automatic t_regs();
        rd(OFS_CLOCK_CONTROL, 16'h0100);
        rd(OFS_CONTROL, 16'h1e00);
        rd(OFS_FLAG, 16'h0000);
        rd(OFS_IRQ_ENABLE, 16'h0000);
        rd(4'ha, 16'h0000);
        wr(OFS_CONTROL, 16'h1e01);
        rd(OFS_CONTROL, 16'h1e00);
        wr(OFS_PROTECTION_KEY, PROT_UNLOCK);
        wr(OFS_CLOCK_CONTROL, 16'h0050);
        rd(OFS_CLOCK_CONTROL, 16'h0050);
        wr(OFS_CLOCK_CONTROL, 16'h0001);
        rd(OFS_CLOCK_CONTROL, 16'h0001);
    endtask
    task automatic t_cont();
        wr(OFS_IRQ_ENABLE, 16'h0001);
        wr(OFS_CONTROL, 16'h7e01);
        wr(OFS_CONTROL, 16'h7d01);
        repeat (60) @(posedge clk);
        rd(OFS_CONTROL, 16'h1d01);
        chk({11'h000, threshold_select}, 16'h001d);
        chk({15'h0000, comparator_power}, 16'h0001);
        rd(OFS_FLAG, 16'h0000);
        comparator_low <= 1'b1;
        wait_for(1'b0, 1'b1, 200);
        rd(OFS_FLAG, 16'h0101);
        comparator_low <= 1'b0;
        repeat (60) @(posedge clk);
        rd(OFS_FLAG, 16'h0001);
        wr(OFS_IRQ_ENABLE, 16'h0000);
        #1 chk({15'h0000, irq}, 16'h0000);
        wr(OFS_FLAG, 16'h0001);
        rd(OFS_FLAG, 16'h0000);
    endtask
    task automatic t_interval();
        wr(OFS_IRQ_ENABLE, 16'h0001);
        wr(OFS_CONTROL, 16'h1e03);
        comparator_low <= 1'b1;
        wr(OFS_CONTROL, 16'h3e03);
        rd(OFS_CONTROL, 16'h3e03);
        repeat (700) @(posedge clk);
        #1 chk({15'h0000, comparator_power}, 16'h0000);
        rd(OFS_FLAG, 16'h0100);
        wait_for(1'b0, 1'b1, 300);
        comparator_low <= 1'b0;
        wr(OFS_CONTROL, 16'h1e00);
        wr(OFS_FLAG, 16'h0001);
    endtask
    task automatic t_reset_issue();
        wr(OFS_CONTROL, 16'h9ea3);
        comparator_low <= 1'b1;
        wait_for(1'b1, 1'b1, 1000);
        chk({15'h0000, irq}, 16'h0000);
        chk({15'h0000, external_sense_route}, 16'h0001);
        rd(OFS_CONTROL, 16'h9ea1);
        rd(OFS_FLAG, 16'h0101);
        rd(OFS_IRQ_ENABLE, 16'h0000);
        rd(OFS_CLOCK_CONTROL, 16'h0100);
        comparator_low <= 1'b0;
        wait_for(1'b1, 1'b0, 300);
    endtask
    task automatic t_debug();
        wr(OFS_CLOCK_CONTROL, 16'h0001);
        wr(OFS_CONTROL, 16'h1e01);
        wr(OFS_FLAG, 16'h0001);
        debug_mode <= 1'b1;
        comparator_low <= 1'b1;
        repeat (100) @(posedge clk);
        rd(OFS_FLAG, 16'h0000);
        debug_mode <= 1'b0;
        repeat (60) @(posedge clk);
        rd(OFS_FLAG, 16'h0101);
        comparator_low <= 1'b0;
        wr(OFS_CONTROL, 16'h1e00);
        repeat (4) @(posedge clk);
        rd(OFS_CONTROL, 16'h1e00);
        wr(OFS_PROTECTION_KEY, 16'h0000);
        wr(OFS_CONTROL, 16'h1e01);
        rd(OFS_CONTROL, 16'h1e00);
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        osc = 1'b0;
        osc_cnt = 2'h0;
        debug_mode = 1'b0;
        comparator_low = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_cont();
        t_interval();
        t_reset_issue();
        t_debug();
        stop_test();
    end
endmodule
